/* hdl/rrte_pkg.sv */
package rrte_pkg;
   localparam int unsigned OPC_W  = 10;
   localparam int unsigned NIB_W  = 4;
   localparam int unsigned D_W    = 3;
   localparam int unsigned Z_W    = 2;
   localparam int unsigned E_W    = 8;
   localparam int unsigned STK_W  = 3;
   localparam int unsigned PTR_W  = Z_W + 2 * NIB_W;

   localparam logic [9:0] OPC_COPY_B_TO_A   = 10'h01e;
   localparam logic [9:0] OPC_COPY_A_TO_B   = 10'h00e;
   localparam logic [9:0] OPC_COPY_Y_TO_A   = 10'h01f;
   localparam logic [9:0] OPC_COPY_A_TO_Y   = 10'h00c;
   localparam logic [9:0] OPC_PACK_AB_TO_E  = 10'h01a;
   localparam logic [9:0] OPC_UNPACK_E      = 10'h02a;
   localparam logic [9:0] OPC_COPY_A_TO_D   = 10'h029;
   localparam logic [9:0] OPC_COPY_D_TO_A   = 10'h051;
   localparam logic [9:0] OPC_COPY_Z_TO_A   = 10'h053;
   localparam logic [9:0] OPC_COPY_X_TO_A   = 10'h052;
   localparam logic [9:0] OPC_COPY_SP_TO_A  = 10'h050;
   localparam logic [9:0] OPC_INCREMENT_Y   = 10'h013;
   localparam logic [9:0] OPC_DECREMENT_Y   = 10'h017;
   localparam logic [1:0] PFX_LOAD_XY       = 2'h3;
   localparam logic [7:0] PFX_LOAD_Z        = 8'h12;
   localparam logic [5:0] PFX_LOAD_A_RAM    = 6'h2c;
   localparam logic [5:0] PFX_SWAP          = 6'h2d;
   localparam logic [5:0] PFX_SWAP_DEC      = 6'h2f;
   localparam logic [5:0] PFX_SWAP_INC      = 6'h2e;
   localparam logic [5:0] PFX_STORE_A       = 6'h2b;

   localparam int unsigned IMM_HI_LSB = 4;
   localparam int unsigned IMM_LSB   = 0;

   localparam logic [3:0] RST_NIB    = 4'h0;
   localparam logic [2:0] RST_D      = 3'h0;
   localparam logic [1:0] RST_Z      = 2'h0;
   localparam logic [7:0] RST_E      = 8'h00;
   localparam logic [3:0] Y_SKIP_INC = 4'h0;
   localparam logic [3:0] Y_SKIP_DEC = 4'hf;
   localparam logic [3:0] ONE_NIB    = 4'h1;

   typedef enum logic [4:0] {
      OP_NONE,
      OP_COPY_B_TO_A,
      OP_COPY_A_TO_B,
      OP_COPY_Y_TO_A,
      OP_COPY_A_TO_Y,
      OP_PACK_AB_TO_E,
      OP_UNPACK_E_TO_AB,
      OP_COPY_A_TO_D,
      OP_COPY_D_TO_A,
      OP_COPY_Z_TO_A,
      OP_COPY_X_TO_A,
      OP_COPY_SP_TO_A,
      OP_LOAD_XY_IMM,
      OP_LOAD_Z_IMM,
      OP_INCREMENT_Y,
      OP_DECREMENT_Y,
      OP_LOAD_A_RAM_XOR,
      OP_SWAP_A_RAM_XOR,
      OP_SWAP_A_RAM_XOR_DEC,
      OP_SWAP_A_RAM_XOR_INC,
      OP_STORE_A_RAM_XOR
   } rrte_op_type;
endpackage

/* hdl/rrte_dec_if.sv */
`timescale 1ns/1ns
interface rrte_dec_if;
   logic [rrte_pkg::OPC_W-1:0] opcode;
   rrte_pkg::rrte_op_type      op;
   logic [rrte_pkg::NIB_W-1:0] imm_lo;
   logic [rrte_pkg::NIB_W-1:0] imm_hi;

   modport dec (input opcode, output op, output imm_lo, output imm_hi);
   modport exe (output opcode, input op, input imm_lo, input imm_hi);
endinterface

/* hdl/rrte_decode.sv */
`timescale 1ns/1ns
module rrte_decode (
   rrte_dec_if.dec dec
);
   function automatic rrte_pkg::rrte_op_type decode_op(input logic [9:0] opc);
      rrte_pkg::rrte_op_type r;
      r = rrte_pkg::OP_NONE;
      if (opc[9:8] == rrte_pkg::PFX_LOAD_XY) begin
         r = rrte_pkg::OP_LOAD_XY_IMM;
      end else if (opc[9:2] == rrte_pkg::PFX_LOAD_Z) begin
         r = rrte_pkg::OP_LOAD_Z_IMM;
      end else if (opc[9:4] == rrte_pkg::PFX_LOAD_A_RAM) begin
         r = rrte_pkg::OP_LOAD_A_RAM_XOR;
      end else if (opc[9:4] == rrte_pkg::PFX_SWAP) begin
         r = rrte_pkg::OP_SWAP_A_RAM_XOR;
      end else if (opc[9:4] == rrte_pkg::PFX_SWAP_DEC) begin
         r = rrte_pkg::OP_SWAP_A_RAM_XOR_DEC;
      end else if (opc[9:4] == rrte_pkg::PFX_SWAP_INC) begin
         r = rrte_pkg::OP_SWAP_A_RAM_XOR_INC;
      end else if (opc[9:4] == rrte_pkg::PFX_STORE_A) begin
         r = rrte_pkg::OP_STORE_A_RAM_XOR;
      end else begin
         case (opc)
            rrte_pkg::OPC_COPY_B_TO_A:  r = rrte_pkg::OP_COPY_B_TO_A;
            rrte_pkg::OPC_COPY_A_TO_B:  r = rrte_pkg::OP_COPY_A_TO_B;
            rrte_pkg::OPC_COPY_Y_TO_A:  r = rrte_pkg::OP_COPY_Y_TO_A;
            rrte_pkg::OPC_COPY_A_TO_Y:  r = rrte_pkg::OP_COPY_A_TO_Y;
            rrte_pkg::OPC_PACK_AB_TO_E: r = rrte_pkg::OP_PACK_AB_TO_E;
            rrte_pkg::OPC_UNPACK_E:     r = rrte_pkg::OP_UNPACK_E_TO_AB;
            rrte_pkg::OPC_COPY_A_TO_D:  r = rrte_pkg::OP_COPY_A_TO_D;
            rrte_pkg::OPC_COPY_D_TO_A:  r = rrte_pkg::OP_COPY_D_TO_A;
            rrte_pkg::OPC_COPY_Z_TO_A:  r = rrte_pkg::OP_COPY_Z_TO_A;
            rrte_pkg::OPC_COPY_X_TO_A:  r = rrte_pkg::OP_COPY_X_TO_A;
            rrte_pkg::OPC_COPY_SP_TO_A: r = rrte_pkg::OP_COPY_SP_TO_A;
            rrte_pkg::OPC_INCREMENT_Y:  r = rrte_pkg::OP_INCREMENT_Y;
            rrte_pkg::OPC_DECREMENT_Y:  r = rrte_pkg::OP_DECREMENT_Y;
            default:                    r = rrte_pkg::OP_NONE;
         endcase
      end
      return r;
   endfunction

   always_comb begin
      dec.op     = decode_op(dec.opcode);
      dec.imm_lo = dec.opcode[rrte_pkg::IMM_LSB +: rrte_pkg::NIB_W];
      dec.imm_hi = dec.opcode[rrte_pkg::IMM_HI_LSB +: rrte_pkg::NIB_W];
   end
endmodule

/* hdl/rrte_exec.sv */
`timescale 1ns/1ns
module rrte_exec (
   input  wire logic                        clk_sys_i,
   input  wire logic                        nrst_i,
   input  wire logic                        instr_valid_i,
   input  wire logic [rrte_pkg::OPC_W-1:0]  opcode_i,
   input  wire logic [rrte_pkg::STK_W-1:0]  stack_ptr_i,
   input  wire logic [rrte_pkg::NIB_W-1:0]  ram_rdata_i,
   output logic      [rrte_pkg::PTR_W-1:0]  data_pointer_o,
   output logic                             ram_we_o,
   output logic      [rrte_pkg::PTR_W-1:0]  ram_waddr_o,
   output logic      [rrte_pkg::NIB_W-1:0]  ram_wdata_o,
   output logic                             handled_o,
   output logic                             skip_o,
   output logic      [rrte_pkg::NIB_W-1:0]  a_o,
   output logic      [rrte_pkg::NIB_W-1:0]  b_o,
   output logic      [rrte_pkg::NIB_W-1:0]  x_o,
   output logic      [rrte_pkg::NIB_W-1:0]  y_o,
   output logic      [rrte_pkg::Z_W-1:0]    z_o,
   output logic      [rrte_pkg::D_W-1:0]    d_o,
   output logic      [rrte_pkg::E_W-1:0]    e_o
);
   rrte_dec_if dif ();

   rrte_decode u_decode (
      .dec (dif)
   );

   logic [3:0] a_reg;
   logic [3:0] a_next;
   logic [3:0] b_reg;
   logic [3:0] b_next;
   logic [3:0] x_reg;
   logic [3:0] x_next;
   logic [3:0] y_reg;
   logic [3:0] y_next;
   logic [1:0] z_reg;
   logic [1:0] z_next;
   logic [2:0] d_reg;
   logic [2:0] d_next;
   logic [7:0] e_reg;
   logic [7:0] e_next;
   logic       skip_reg;
   logic       skip_next;
   logic       chain_reg;
   logic       chain_next;
   logic       we_reg;
   logic       we_next;
   logic [9:0] waddr_reg;
   logic [9:0] waddr_next;
   logic [3:0] wdata_reg;
   logic [3:0] wdata_next;
   logic       exec;
   logic       is_load_xy;

   function automatic logic [3:0] y_step(input logic [3:0] y, input logic up);
      return up ? 4'(y + rrte_pkg::ONE_NIB) : 4'(y - rrte_pkg::ONE_NIB);
   endfunction

   assign dif.opcode = opcode_i;
   assign is_load_xy = (dif.op == rrte_pkg::OP_LOAD_XY_IMM);

   assign exec = instr_valid_i && !skip_reg && !(is_load_xy && chain_reg);

   always_comb begin
      a_next        = a_reg;
      b_next        = b_reg;
      x_next        = x_reg;
      y_next        = y_reg;
      z_next        = z_reg;
      d_next        = d_reg;
      e_next        = e_reg;
      skip_next     = skip_reg;
      chain_next    = chain_reg;
      we_next       = 1'b0;
      waddr_next    = waddr_reg;
      wdata_next    = wdata_reg;
      if (instr_valid_i) begin
         // Skipped instructions still count for the load_xy_imm chain
         skip_next     = 1'b0;
         chain_next    = is_load_xy;
      end
      if (exec) begin
         case (dif.op)
            rrte_pkg::OP_COPY_B_TO_A: a_next = b_reg;
            rrte_pkg::OP_COPY_A_TO_B: b_next = a_reg;
            rrte_pkg::OP_COPY_Y_TO_A: a_next = y_reg;
            rrte_pkg::OP_COPY_A_TO_Y: y_next = a_reg;
            rrte_pkg::OP_PACK_AB_TO_E: e_next = {b_reg, a_reg};
            rrte_pkg::OP_UNPACK_E_TO_AB: begin
               b_next = e_reg[7:4];
               a_next = e_reg[3:0];
            end
            rrte_pkg::OP_COPY_A_TO_D: d_next = a_reg[2:0];
            rrte_pkg::OP_COPY_D_TO_A: a_next = {1'b0, d_reg};
            rrte_pkg::OP_COPY_Z_TO_A: a_next = {2'b00, z_reg};
            rrte_pkg::OP_COPY_X_TO_A: a_next = x_reg;
            rrte_pkg::OP_COPY_SP_TO_A: a_next = {1'b0, stack_ptr_i};
            rrte_pkg::OP_LOAD_XY_IMM: begin
               x_next = dif.imm_hi;
               y_next = dif.imm_lo;
            end
            rrte_pkg::OP_LOAD_Z_IMM: z_next = dif.imm_lo[1:0];
            rrte_pkg::OP_INCREMENT_Y,
            rrte_pkg::OP_DECREMENT_Y: y_next = y_step(y_reg, dif.op == rrte_pkg::OP_INCREMENT_Y);
            rrte_pkg::OP_LOAD_A_RAM_XOR: begin
               a_next = ram_rdata_i;
               x_next = x_reg ^ dif.imm_lo;
            end
            rrte_pkg::OP_SWAP_A_RAM_XOR,
            rrte_pkg::OP_SWAP_A_RAM_XOR_DEC,
            rrte_pkg::OP_SWAP_A_RAM_XOR_INC: begin
               a_next     = ram_rdata_i;
               we_next    = 1'b1;
               waddr_next = data_pointer_o;
               wdata_next = a_reg;
               x_next     = x_reg ^ dif.imm_lo;
               if (dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_DEC) begin
                  y_next = y_step(y_reg, 1'b0);
               end else if (dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_INC) begin
                  y_next = y_step(y_reg, 1'b1);
               end
            end
            rrte_pkg::OP_STORE_A_RAM_XOR: begin
               we_next    = 1'b1;
               waddr_next = data_pointer_o;
               wdata_next = a_reg;
               x_next     = x_reg ^ dif.imm_lo;
            end
            default: begin
            end
         endcase
         if (dif.op == rrte_pkg::OP_INCREMENT_Y || dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_INC) begin
            skip_next = (y_next == rrte_pkg::Y_SKIP_INC);
         end else if (dif.op == rrte_pkg::OP_DECREMENT_Y || dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_DEC) begin
            skip_next = (y_next == rrte_pkg::Y_SKIP_DEC);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_reg        <= rrte_pkg::RST_NIB;
         b_reg        <= rrte_pkg::RST_NIB;
         x_reg        <= rrte_pkg::RST_NIB;
         y_reg        <= rrte_pkg::RST_NIB;
         z_reg        <= rrte_pkg::RST_Z;
         d_reg        <= rrte_pkg::RST_D;
         e_reg        <= rrte_pkg::RST_E;
         skip_reg     <= 1'b0;
         chain_reg    <= 1'b0;
         we_reg       <= 1'b0;
         waddr_reg    <= 10'h000;
         wdata_reg    <= rrte_pkg::RST_NIB;
      end else begin
         a_reg        <= a_next;
         b_reg        <= b_next;
         x_reg        <= x_next;
         y_reg        <= y_next;
         z_reg        <= z_next;
         d_reg        <= d_next;
         e_reg        <= e_next;
         skip_reg     <= skip_next;
         chain_reg    <= chain_next;
         we_reg       <= we_next;
         waddr_reg    <= waddr_next;
         wdata_reg    <= wdata_next;
      end
   end

   // Write lands one cycle after the swap, so RAM must not be reread that cycle
   assign data_pointer_o = {z_reg, x_reg, y_reg};
   assign ram_we_o       = we_reg;
   assign ram_waddr_o    = waddr_reg;
   assign ram_wdata_o    = wdata_reg;
   assign handled_o      = instr_valid_i && (dif.op != rrte_pkg::OP_NONE);
   assign skip_o         = skip_reg;
   assign a_o            = a_reg;
   assign b_o            = b_reg;
   assign x_o            = x_reg;
   assign y_o            = y_reg;
   assign z_o            = z_reg;
   assign d_o            = d_reg;
   assign e_o            = e_reg;

   a_copy_b_a : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_B_TO_A |=> a_reg == $past(b_reg) && b_reg == $past(b_reg))
      else $error("copy_b_to_a result wrong");

   a_copy_a_b : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_A_TO_B |=> b_reg == $past(a_reg))
      else $error("copy_a_to_b result wrong");

   a_copy_y_a : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_Y_TO_A |=> a_reg == $past(y_reg))
      else $error("copy_y_to_a result wrong");

   a_copy_a_y : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_A_TO_Y |=> y_reg == $past(a_reg))
      else $error("copy_a_to_y result wrong");

   a_a_to_d : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_A_TO_D |=> d_reg == $past(a_reg[2:0]))
      else $error("copy_a_to_d result wrong");

   a_d_to_a : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_D_TO_A |=> a_reg == {1'b0, $past(d_reg)})
      else $error("copy_d_to_a result wrong");

   a_z_to_a : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_Z_TO_A |=> a_reg == {2'b00, $past(z_reg)})
      else $error("copy_z_to_a result wrong");

   a_load_z : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_LOAD_Z_IMM |=> z_reg == $past(opcode_i[1:0]))
      else $error("load_z_imm result wrong");

   a_store_write : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_STORE_A_RAM_XOR
      |=> ram_we_o && ram_wdata_o == $past(a_reg) && ram_waddr_o == $past(data_pointer_o) && a_reg == $past(a_reg))
      else $error("store_a_to_ram_xor write wrong");

   a_pack_e : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_PACK_AB_TO_E |=> e_reg == {$past(b_reg), $past(a_reg)})
      else $error("pack_ab_to_e result wrong");

   a_unpack_e : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_UNPACK_E_TO_AB |=> b_reg == $past(e_reg[7:4]) && a_reg == $past(e_reg[3:0]))
      else $error("unpack_e_to_ab result wrong");

   a_sp_to_a : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_COPY_SP_TO_A |=> a_reg == {1'b0, $past(stack_ptr_i)})
      else $error("copy_sp_to_a result wrong");

   a_load_xy : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && opcode_i[9:8] == 2'h3 |=> x_reg == $past(opcode_i[7:4]) && y_reg == $past(opcode_i[3:0]))
      else $error("load_xy_imm result wrong");

   a_xor_x : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && (dif.op == rrte_pkg::OP_LOAD_A_RAM_XOR || dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR ||
               dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_DEC || dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_INC ||
               dif.op == rrte_pkg::OP_STORE_A_RAM_XOR)
      |=> x_reg == ($past(x_reg) ^ $past(opcode_i[3:0])))
      else $error("X xor immediate wrong");

   a_swap_write : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR
      |=> ram_we_o && ram_wdata_o == $past(a_reg) && a_reg == $past(ram_rdata_i) ##1 (!ram_we_o || $past(exec)))
      else $error("swap_a_ram_xor exchange wrong");

   a_inc_skip : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_INCREMENT_Y |=> y_reg == 4'($past(y_reg) + 4'h1) && skip_o == (y_reg == 4'h0))
      else $error("increment_y skip wrong");

   a_dec_skip : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      exec && dif.op == rrte_pkg::OP_SWAP_A_RAM_XOR_DEC |=> skip_o == ($past(y_reg) == 4'h0))
      else $error("swap_a_ram_xor_dec skip wrong");

   a_xy_chain : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      instr_valid_i && is_load_xy && chain_reg
      |=> $stable(x_reg) && $stable(y_reg))
      else $error("following load_xy_imm not skipped");

   a_skip_held : assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      instr_valid_i && skip_reg |=> $stable(a_reg) && $stable(x_reg) && $stable(y_reg) && !skip_o)
      else $error("skipped instruction changed state");
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   logic       clk_sys_i;
   logic       nrst_i;
   logic       instr_valid_i;
   logic [9:0] opcode_i;
   logic [2:0] stack_ptr_i;
   logic [3:0] ram_rdata_i;
   logic [9:0] data_pointer_o;
   logic       ram_we_o;
   logic [9:0] ram_waddr_o;
   logic [3:0] ram_wdata_o;
   logic       handled_o;
   logic       skip_o;
   logic [3:0] a_o;
   logic [3:0] b_o;
   logic [3:0] x_o;
   logic [3:0] y_o;
   logic [1:0] z_o;
   logic [2:0] d_o;
   logic [7:0] e_o;
   logic       hnd;
   int         errors;
   int         checked;

   rrte_exec rrte_exec_i (
      .clk_sys_i      (clk_sys_i),
      .nrst_i         (nrst_i),
      .instr_valid_i  (instr_valid_i),
      .opcode_i       (opcode_i),
      .stack_ptr_i    (stack_ptr_i),
      .ram_rdata_i    (ram_rdata_i),
      .data_pointer_o (data_pointer_o),
      .ram_we_o       (ram_we_o),
      .ram_waddr_o    (ram_waddr_o),
      .ram_wdata_o    (ram_wdata_o),
      .handled_o      (handled_o),
      .skip_o         (skip_o),
      .a_o            (a_o),
      .b_o            (b_o),
      .x_o            (x_o),
      .y_o            (y_o),
      .z_o            (z_o),
      .d_o            (d_o),
      .e_o            (e_o)
   );

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic stop_test();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Values are zero-extended so one compare serves every register width
   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One instruction, then one idle cycle so a RAM write lands before any read
   task automatic run(input logic [9:0] op, input logic [3:0] r = 4'h0);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      opcode_i      <= op;
      ram_rdata_i   <= r;
      #1 hnd = handled_o;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      #1;
   endtask

   task automatic t_reset();
      chk("a", 10'h000, a_o);
      chk("b", 10'h000, b_o);
      chk("e", 10'h000, e_o);
      chk("data_pointer", 10'h000, data_pointer_o);
      chk("skip", 10'h000, skip_o);
      chk("we", 10'h000, ram_we_o);
   endtask

   task automatic t_lxy();
      run(10'h3a5);
      chk("x", 10'h00a, x_o);
      chk("y", 10'h005, y_o);
      run(10'h312);
      chk("handled", 10'h001, hnd);
      chk("x", 10'h00a, x_o);
      chk("y", 10'h005, y_o);
      run(10'h01f);
      chk("a", 10'h005, a_o);
      run(10'h3c7);
      chk("x", 10'h00c, x_o);
      chk("y", 10'h007, y_o);
   endtask

   task automatic t_copies();
      run(10'h2c0, 4'h9);
      chk("a", 10'h009, a_o);
      chk("x", 10'h00c, x_o);
      run(10'h00e);
      chk("b", 10'h009, b_o);
      run(10'h2c0, 4'h6);
      run(10'h01a);
      chk("e", 10'h096, e_o);
      run(10'h2c0, 4'h1);
      run(10'h00e);
      run(10'h02a);
      chk("b", 10'h009, b_o);
      chk("a", 10'h006, a_o);
      run(10'h01e);
      chk("a", 10'h009, a_o);
      chk("b", 10'h009, b_o);
      run(10'h00c);
      chk("y", 10'h009, y_o);
      run(10'h2c0, 4'he);
      run(10'h029);
      chk("d", 10'h006, d_o);
      run(10'h2c0, 4'hf);
      run(10'h051);
      chk("a", 10'h006, a_o);
      run(10'h04b);
      chk("z", 10'h003, z_o);
      chk("data_pointer", {2'h3, 4'hc, 4'h9}, data_pointer_o);
      run(10'h2c0, 4'hf);
      run(10'h053);
      chk("a", 10'h003, a_o);
      run(10'h052);
      chk("a", 10'h00c, a_o);
      stack_ptr_i <= 3'h5;
      run(10'h050);
      chk("a", 10'h005, a_o);
   endtask

   // Table of the five RAM transfers: X starts at 5, Y at 8, A at c, RAM reads a
   task automatic t_ram();
      logic [9:0] ops [5];
      logic [3:0] ea [5];
      logic [3:0] ey [5];
      logic       ew [5];
      ops = '{10'h2c3, 10'h2d3, 10'h2f3, 10'h2e3, 10'h2b3};
      ea  = '{4'ha, 4'ha, 4'ha, 4'ha, 4'hc};
      ey  = '{4'h8, 4'h8, 4'h7, 4'h9, 4'h8};
      ew  = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      for (int i = 0; i < 5; i++) begin
         run(10'h358);
         run(10'h2c0, 4'hc);
         run(ops[i], 4'ha);
         chk("handled", 10'h001, hnd);
         chk("a", ea[i], a_o);
         chk("x", 10'h006, x_o);
         chk("y", ey[i], y_o);
         chk("skip", 10'h000, skip_o);
         chk("we", ew[i], ram_we_o);
         if (ew[i]) begin
            chk("wdata", 10'h00c, ram_wdata_o);
            chk("waddr", {2'h3, 4'h5, 4'h8}, ram_waddr_o);
         end
         @(posedge clk_sys_i);
         #1 chk("we", 10'h000, ram_we_o);
      end
   endtask

   task automatic t_skip();
      run(10'h30f);
      run(10'h013);
      chk("y", 10'h000, y_o);
      chk("skip", 10'h001, skip_o);
      run(10'h00e);
      chk("handled", 10'h001, hnd);
      chk("b", 10'h009, b_o);
      chk("skip", 10'h000, skip_o);
      run(10'h017);
      chk("y", 10'h00f, y_o);
      chk("skip", 10'h001, skip_o);
      run(10'h2d1, 4'h3);
      chk("a", 10'h00c, a_o);
      chk("x", 10'h000, x_o);
      chk("we", 10'h000, ram_we_o);
      run(10'h017);
      chk("y", 10'h00e, y_o);
      chk("skip", 10'h000, skip_o);
      run(10'h2e0, 4'h2);
      chk("skip", 10'h000, skip_o);
      run(10'h2e0, 4'h2);
      chk("y", 10'h000, y_o);
      chk("skip", 10'h001, skip_o);
      run(10'h013);
      chk("y", 10'h000, y_o);
      run(10'h2f0, 4'h1);
      chk("y", 10'h00f, y_o);
      chk("skip", 10'h001, skip_o);
      run(10'h000);
      chk("handled", 10'h000, hnd);
      chk("skip", 10'h000, skip_o);
   endtask

   // Every wait is a fixed cycle count; this bound only catches a stuck run
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      errors++;
      stop_test();
   end

   initial begin
      clk_sys_i     = 1'b0;
      nrst_i        = 1'b0;
      instr_valid_i = 1'b0;
      opcode_i      = 10'h000;
      stack_ptr_i   = 3'h0;
      ram_rdata_i   = 4'h0;
      errors        = 0;
      checked       = 0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      #1;
      t_reset();
      t_lxy();
      t_copies();
      t_ram();
      t_skip();
      stop_test();
   end
endmodule
